/* File: shared/xspi_regwrite_pkg.sv */
// constants and types for the register-write command block and sector map
package xspi_regwrite_pkg;

  // ****************************************
  // command opcodes
  // ****************************************
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
  localparam logic [7:0] OP_WRITE_NVCFG = 8'hb1;
  localparam logic [7:0] OP_WRITE_VCFG = 8'h81;
  localparam logic [7:0] OP_CLEAR_FLAGS = 8'h50;

  // ****************************************
  // status and flag status layout
  // ****************************************
  localparam int STATUS_WIP_BIT = 0;
  localparam int STATUS_WEL_BIT = 1;
  localparam int STATUS_LOCK_BIT = 7;
  localparam logic [7:0] STATUS_WRITABLE_MASK = 8'hfc;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int FLAG_READY_BIT = 7;
  localparam int FLAG_REFUSED_BIT = 4;
  localparam int FLAG_PROTECT_BIT = 1;
  localparam logic [7:0] FLAG_ERROR_MASK = 8'h3a;
  localparam logic [7:0] FLAG_RESET = 8'h00;

  // ****************************************
  // configuration registers
  // ****************************************
  localparam logic [7:0] CFG_RESERVED_MASK = 8'hc0;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // ****************************************
  // frame layout: opcode, then address or data
  // ****************************************
  localparam int FRAME_OPCODE_POS = 0;
  localparam int FRAME_ADDR_POS = 1;
  localparam int FRAME_STATUS_DATA_POS = 1;
  localparam int FRAME_CFG_DATA_POS = 2;

  // ****************************************
  // array organisation
  // ****************************************
  localparam int ADDR_W = 24;
  localparam int SUB4_LSB = 12;
  localparam int SUB32_LSB = 15;
  localparam int SECTOR_LSB = 16;
  localparam logic [23:0] TOP_ADDR_4M = 24'h07ffff;
  localparam logic [23:0] TOP_ADDR_8M = 24'h0fffff;
  localparam logic [23:0] TOP_ADDR_16M = 24'h1fffff;

  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 100;
  localparam int NV_WRITE_TIME_NS = 50000;

  typedef enum logic [1:0] {
    EXEC_IDLE = 2'b00,
    EXEC_STATUS = 2'b01,
    EXEC_NVCFG = 2'b10
  } exec_state_type;

  typedef struct packed {
    logic inRange;
    logic [4:0] sector;
    logic [5:0] sub32;
    logic [8:0] sub4;
    logic [23:0] sub4Start;
  } sector_info_type;

endpackage

/* File: src/xspi_regwrite.sv */
// register-write command handling and sector map of the serial memory
//
// How it works
// - status write loads bits 7:2 from the data byte.
// - status write never alters status bits 1 and 0.
// - lock bit plus low write-protect pin refuses the status write.
// - write-in-progress reads 1 while status or nonvolatile write runs.
// - write-enable latch stays set after those writes, pass or fail.
// - write-in-progress returns to 0 when they finish, pass or fail.
// - status and flag status stay readable during every write.
// - volatile configuration write takes effect at once, no busy time.
// - volatile configuration write keeps reserved bits unchanged.
// - clear-flags command zeroes flag bits 5, 4, 3 and 1 only.
// - first data byte goes into the addressed register in 8d mode.
// - further configuration bytes go to incrementing register addresses.
// - 8d configuration writes always store bytes in pairs.
// - 64KB sectors hold two 32KB halves, each of eight 4KB pieces.
// - 16Mb part ends with 4KB subsector 511 at 1FFFFFh.
// - 8Mb part ends with 4KB subsector 255 at 0FFFFFh.
// - 4Mb part ends with subsector 127, sector 7, at 07FFFFh.
// - subsector index is address bits 20 to 12, zero at address zero.
`timescale 1ns/1ps

module xspi_regwrite
  import xspi_regwrite_pkg::*;
#(
  parameter int DENSITY_MBIT = 16,
  parameter int CFG_REGS = 8,
  parameter int NV_WRITE_TIME = NV_WRITE_TIME_NS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic linkClk,
  input wire logic chipSelect_n,
  input wire logic [7:0] linkData,
  input wire logic writeProtect_n,
  input wire logic dtrMode,
  input wire logic [ADDR_W-1:0] eraseAddr,
  output logic [7:0] statusReg,
  output logic [7:0] flagStatus,
  output logic [CFG_REGS*8-1:0] nvConfig,
  output logic [CFG_REGS*8-1:0] vConfig,
  output sector_info_type sectorInfo
);

  // ****************************************
  // derived sizes and elaboration checks
  // ****************************************
  localparam int MAX_BYTES = FRAME_CFG_DATA_POS + CFG_REGS;
  localparam int CNT_W = $clog2(MAX_BYTES + 1);
  localparam int NV_CYCLES_RAW =
    (NV_WRITE_TIME + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NV_CYCLES = (NV_CYCLES_RAW < 1) ? 1 : NV_CYCLES_RAW;
  localparam int TIMER_W = $clog2(NV_CYCLES + 1);
  localparam logic [23:0] TOP_ADDR =
    (DENSITY_MBIT == 4) ? TOP_ADDR_4M :
    (DENSITY_MBIT == 8) ? TOP_ADDR_8M : TOP_ADDR_16M;

  generate
    if (DENSITY_MBIT != 4 && DENSITY_MBIT != 8 && DENSITY_MBIT != 16) begin
      $error("density must be 4, 8 or 16");
    end
    if (CFG_REGS < 2 || CFG_REGS > 256 || (CFG_REGS % 2) != 0) begin
      $error("configuration register count must be even, 2 to 256");
    end
  endgenerate

  // ****************************************
  // helper functions
  // ****************************************
  function automatic sector_info_type mapAddress(input logic [23:0] a);
    sector_info_type s;
    s.inRange = (a <= TOP_ADDR);
    s.sector = a[SECTOR_LSB +: 5];
    s.sub32 = a[SUB32_LSB +: 6];
    s.sub4 = a[SUB4_LSB +: 9];
    s.sub4Start = {a[ADDR_W-1:SUB4_LSB], 12'h000};
    return s;
  endfunction

  // keeps reserved positions of the old value
  function automatic logic [7:0] mergeCfg(input logic [7:0] oldV,
                                          input logic [7:0] newV);
    return (oldV & CFG_RESERVED_MASK) | (newV & ~CFG_RESERVED_MASK);
  endfunction

  // ****************************************
  // link domain: frame capture
  // ****************************************
  // armed is forced high by the deselect before each frame, so the first edge
  // of each frame restarts the byte count even though the link clock
  // stands still between frames
  logic armed_q;
  logic [CNT_W-1:0] linkCount_q;
  logic [7:0] linkBuf_q [MAX_BYTES];

  always_ff @(posedge linkClk or posedge chipSelect_n) begin
    if (chipSelect_n) begin
      armed_q <= 1'b1;
    end else begin
      armed_q <= 1'b0;
    end
  end

  always_ff @(posedge linkClk) begin
    if (armed_q) begin
      linkCount_q <= CNT_W'(1);
    end else if (linkCount_q < CNT_W'(MAX_BYTES)) begin
      linkCount_q <= linkCount_q + CNT_W'(1);
    end
  end

  // bytes past the buffer are dropped; count saturates
  always_ff @(posedge linkClk) begin
    if (armed_q) begin
      linkBuf_q[FRAME_OPCODE_POS] <= linkData;
    end else if (linkCount_q < CNT_W'(MAX_BYTES)) begin
      linkBuf_q[linkCount_q] <= linkData;
    end
  end

  // ****************************************
  // crossing into the system clock
  // ****************************************
  // buffer and count are stable while select is high; they are read in
  // the single cycle after the synchronised rising edge of select
  logic csSync1_q, csSync2_q, csPrev_q;
  logic wpSync1_q, wpSync2_q;
  logic frameEnd;

  // both pins pass two flops; idle level at reset avoids a false edge
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      csSync1_q <= 1'b1;
      csSync2_q <= 1'b1;
      csPrev_q <= 1'b1;
      wpSync1_q <= 1'b1;
      wpSync2_q <= 1'b1;
    end else begin
      csSync1_q <= chipSelect_n;
      csSync2_q <= csSync1_q;
      csPrev_q <= csSync2_q;
      wpSync1_q <= writeProtect_n;
      wpSync2_q <= wpSync1_q;
    end
  end

  assign frameEnd = csSync2_q & ~csPrev_q;

  // ****************************************
  // command decode
  // ****************************************
  exec_state_type exec_q;
  logic [TIMER_W-1:0] timer_q;
  logic busy, cfgAddrOk, statusLocked, cfgRefused, wel_q, statusFail_q;
  logic doWriteEnable, doStatus, doNvCfg, doVCfg, doClearFlags;
  logic [7:0] opcode, cfgAddrByte, statusBits_q, statusPend_q, flags_q;
  logic [CNT_W-1:0] dataCount, cfgBytes;
  logic [7:0] nvCfg_q [CFG_REGS];
  logic [7:0] nvPend_q [CFG_REGS];
  logic [7:0] vCfg_q [CFG_REGS];

  assign busy = (exec_q != EXEC_IDLE);
  assign opcode = linkBuf_q[FRAME_OPCODE_POS];
  assign cfgAddrByte = linkBuf_q[FRAME_ADDR_POS];
  assign statusLocked = statusBits_q[STATUS_LOCK_BIT] & ~wpSync2_q;

  always_comb begin
    dataCount = '0;
    if (linkCount_q > CNT_W'(FRAME_CFG_DATA_POS)) begin
      dataCount = linkCount_q - CNT_W'(FRAME_CFG_DATA_POS);
    end
    cfgBytes = dataCount;
    if (dtrMode) begin
      cfgBytes = {dataCount[CNT_W-1:1], 1'b0};
    end
    cfgAddrOk = (int'(cfgAddrByte) < CFG_REGS) &&
                !(dtrMode && cfgAddrByte[0]) &&
                (cfgBytes != '0);
  end

  // commands arriving while a timed write runs are ignored
  always_comb begin
    doWriteEnable = frameEnd && !busy && opcode == OP_WRITE_ENABLE;
    doStatus = frameEnd && !busy && opcode == OP_WRITE_STATUS &&
               linkCount_q > CNT_W'(FRAME_STATUS_DATA_POS) && wel_q;
    doNvCfg = frameEnd && !busy && opcode == OP_WRITE_NVCFG &&
              wel_q && cfgAddrOk;
    doVCfg = frameEnd && !busy && opcode == OP_WRITE_VCFG &&
             wel_q && cfgAddrOk;
    doClearFlags = frameEnd && !busy && opcode == OP_CLEAR_FLAGS;
    cfgRefused = frameEnd && !busy && !cfgAddrOk &&
                 (opcode == OP_WRITE_NVCFG || opcode == OP_WRITE_VCFG);
  end

  // ****************************************
  // timed write sequencer
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      exec_q <= EXEC_IDLE;
      timer_q <= '0;
    end else begin
      unique case (exec_q)
        EXEC_IDLE: begin
          if (doStatus) begin
            exec_q <= EXEC_STATUS;
            timer_q <= TIMER_W'(NV_CYCLES);
          end else if (doNvCfg) begin
            exec_q <= EXEC_NVCFG;
            timer_q <= TIMER_W'(NV_CYCLES);
          end
        end
        EXEC_STATUS, EXEC_NVCFG: begin
          if (timer_q == TIMER_W'(1)) begin
            exec_q <= EXEC_IDLE;
          end
          timer_q <= timer_q - TIMER_W'(1);
        end
        default: begin
          exec_q <= EXEC_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // write enable latch
  // ****************************************
  // only the enable command touches it; finishing writes leave it alone
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wel_q <= 1'b0;
    end else if (doWriteEnable) begin
      wel_q <= 1'b1;
    end
  end

  // ****************************************
  // status register
  // ****************************************
  // a locked write still runs its busy time, then changes nothing
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      statusPend_q <= STATUS_RESET;
      statusFail_q <= 1'b0;
    end else if (doStatus) begin
      statusPend_q <= linkBuf_q[FRAME_STATUS_DATA_POS];
      statusFail_q <= statusLocked;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      statusBits_q <= STATUS_RESET;
    end else if (exec_q == EXEC_STATUS && timer_q == TIMER_W'(1) &&
                 !statusFail_q) begin
      statusBits_q <= (statusBits_q & ~STATUS_WRITABLE_MASK) |
                      (statusPend_q & STATUS_WRITABLE_MASK);
    end
  end

  // ****************************************
  // flag status register
  // ****************************************
  // a new error in the clearing cycle survives the clear
  logic [7:0] flagSet;
  always_comb begin
    flagSet = '0;
    flagSet[FLAG_PROTECT_BIT] = doStatus & statusLocked;
    flagSet[FLAG_REFUSED_BIT] = cfgRefused;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      flags_q <= FLAG_RESET;
    end else if (doClearFlags) begin
      flags_q <= (flags_q & ~FLAG_ERROR_MASK) | flagSet;
    end else begin
      flags_q <= flags_q | flagSet;
    end
  end

  // ****************************************
  // nonvolatile configuration registers
  // ****************************************
  // data bytes arrive low byte first at the start address and climb;
  // bytes past the last register are dropped
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < CFG_REGS; i++) begin
        nvPend_q[i] <= CFG_RESET;
      end
    end else if (doNvCfg) begin
      for (int i = 0; i < CFG_REGS; i++) begin
        nvPend_q[i] <= nvCfg_q[i];
        if (i >= int'(cfgAddrByte) &&
            i < int'(cfgAddrByte) + int'(cfgBytes)) begin
          nvPend_q[i] <= mergeCfg(nvCfg_q[i],
            linkBuf_q[FRAME_CFG_DATA_POS + i - int'(cfgAddrByte)]);
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < CFG_REGS; i++) begin
        nvCfg_q[i] <= CFG_RESET;
      end
    end else if (exec_q == EXEC_NVCFG && timer_q == TIMER_W'(1)) begin
      for (int i = 0; i < CFG_REGS; i++) begin
        nvCfg_q[i] <= nvPend_q[i];
      end
    end
  end

  // ****************************************
  // volatile configuration registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      for (int i = 0; i < CFG_REGS; i++) begin
        vCfg_q[i] <= CFG_RESET;
      end
    end else if (doVCfg) begin
      for (int i = 0; i < CFG_REGS; i++) begin
        if (i >= int'(cfgAddrByte) &&
            i < int'(cfgAddrByte) + int'(cfgBytes)) begin
          vCfg_q[i] <= mergeCfg(vCfg_q[i],
            linkBuf_q[FRAME_CFG_DATA_POS + i - int'(cfgAddrByte)]);
        end
      end
    end
  end

  // ****************************************
  // sector map
  // ****************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sectorInfo <= '0;
    end else begin
      sectorInfo <= mapAddress(eraseAddr);
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // registers stay visible at all times, including while busy
  always_comb begin
    statusReg = statusBits_q;
    statusReg[STATUS_WEL_BIT] = wel_q;
    statusReg[STATUS_WIP_BIT] = busy;
    flagStatus = flags_q;
    flagStatus[FLAG_READY_BIT] = ~busy;
    for (int i = 0; i < CFG_REGS; i++) begin
      nvConfig[i*8 +: 8] = nvCfg_q[i];
      vConfig[i*8 +: 8] = vCfg_q[i];
    end
  end

endmodule

/* File: tb/host_link_model.sv */
// host side of the link: byte frames on a gated link clock
`timescale 1ns/1ps
module host_link_model
  import xspi_regwrite_pkg::*;
(
  output logic linkClk,
  output logic chipSelect_n,
  output logic [7:0] linkData
);
  initial begin
    linkClk = 1'b0;
    chipSelect_n = 1'b1;
    linkData = 8'h00;
  end
  // lane has no pull: keep it moving so a stale byte never matches
  always #24 if (chipSelect_n) linkData = ~linkData;
  // link clock stands still outside frames
  task automatic sendFrame(input logic [7:0] f[$]);
    // random lead-in: link clock phase wanders against the system clock
    #($urandom_range(30, 1));
    chipSelect_n = 1'b0;
    foreach (f[k]) begin
      linkData = f[k];
      #24 linkClk = 1'b1;
      #24 linkClk = 1'b0;
    end
    #24 chipSelect_n = 1'b1;
  endtask
endmodule

/* File: tb/xspi_regwrite_checker.sv */
// port assertions for the register-write block
`timescale 1ns/1ps
module xspi_regwrite_checker
  import xspi_regwrite_pkg::*;
#(
  parameter int CFG_REGS = 8,
  parameter int DENSITY_MBIT = 16,
  parameter int NV_WRITE_TIME = NV_WRITE_TIME_NS
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [ADDR_W-1:0] eraseAddr,
  input wire logic [7:0] statusReg,
  input wire logic [7:0] flagStatus,
  input wire logic [CFG_REGS*8-1:0] vConfig,
  input wire sector_info_type sectorInfo
);
  localparam int NV_RAW = (NV_WRITE_TIME + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NV_CYCLES = (NV_RAW < 1) ? 1 : NV_RAW;
  localparam logic [23:0] TOP_ADDR =
    (DENSITY_MBIT == 4) ? TOP_ADDR_4M :
    (DENSITY_MBIT == 8) ? TOP_ADDR_8M : TOP_ADDR_16M;
  logic [CFG_REGS*8-1:0] resMask;
  logic [ADDR_W-1:0] prevAddr;
  int busyRun;
  always_comb begin
    for (int i = 0; i < CFG_REGS; i++) begin
      resMask[8*i+:8] = CFG_RESERVED_MASK;
    end
  end
  // consecutive busy cycles, for the exact length of a timed write
  always_ff @(posedge clk) begin
    prevAddr <= eraseAddr;
    busyRun <= statusReg[0] ? busyRun + 1 : 0;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****************************************
  // register writes
  // ****************************************
  sequence s_busy_hold;
    statusReg[0] [*8];
  endsequence
  property p_busy_span;
    $rose(statusReg[0]) |-> s_busy_hold ##[1:3] !statusReg[0];
  endproperty
  a_busy_span: assert property (p_busy_span)
    else $error("write busy span wrong");
  property p_busy_len;
    $fell(statusReg[0]) |-> busyRun == NV_CYCLES;
  endproperty
  a_busy_len: assert property (p_busy_len)
    else $error("write busy length wrong");
  property p_wel_kept;
    $past(reset_n) |-> !$fell(statusReg[1]);
  endproperty
  a_wel_kept: assert property (p_wel_kept)
    else $error("write enable latch dropped");
  property p_commit;
    $past(reset_n) && $changed(statusReg[7:2]) |-> $fell(statusReg[0]);
  endproperty
  a_commit: assert property (p_commit)
    else $error("status bits changed outside commit");
  property p_ready;
    flagStatus[7] == !statusReg[0];
  endproperty
  a_ready: assert property (p_ready)
    else $error("ready flag disagrees with busy");
  property p_reserved;
    (vConfig & resMask) == '0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved volatile bits changed");
  property p_vcfg_now;
    $past(reset_n) && $changed(vConfig) |-> !statusReg[0];
  endproperty
  a_vcfg_now: assert property (p_vcfg_now)
    else $error("volatile write went busy");
  // ****************************************
  // sector map
  // ****************************************
  property p_sub4;
    $past(reset_n) |-> sectorInfo.sub4 == prevAddr[20:12];
  endproperty
  a_sub4: assert property (p_sub4)
    else $error("4KB index wrong");
  property p_upper;
    $past(reset_n) |-> {sectorInfo.sector, sectorInfo.sub32} ==
      {prevAddr[20:16], prevAddr[20:15]};
  endproperty
  a_upper: assert property (p_upper)
    else $error("sector or 32KB index wrong");
  property p_start;
    $past(reset_n) |-> sectorInfo.sub4Start == {prevAddr[23:12], 12'h000};
  endproperty
  a_start: assert property (p_start)
    else $error("4KB start address wrong");
  property p_range;
    $past(reset_n) |-> sectorInfo.inRange == (prevAddr <= TOP_ADDR);
  endproperty
  a_range: assert property (p_range)
    else $error("range flag wrong");
endmodule
bind xspi_regwrite xspi_regwrite_checker #(.CFG_REGS(CFG_REGS),
  .DENSITY_MBIT(DENSITY_MBIT), .NV_WRITE_TIME(NV_WRITE_TIME))
  xspi_regwrite_checker_i (.clk(clk), .reset_n(reset_n),
  .eraseAddr(eraseAddr), .statusReg(statusReg), .flagStatus(flagStatus),
  .vConfig(vConfig), .sectorInfo(sectorInfo));

/* File: tb/tb_xspi_regwrite.sv */
// self-checking bench for the register-write block and sector map
`timescale 1ns/1ps
module tb_xspi_regwrite;
  import xspi_regwrite_pkg::*;
  logic clk, reset_n, writeProtect_n, dtrMode, linkClk, chipSelect_n;
  logic [7:0] linkData, statusReg, flagStatus;
  logic [ADDR_W-1:0] eraseAddr, a;
  logic [63:0] nvConfig, vConfig;
  sector_info_type sectorInfo;
  int error_cnt, check_count, cycles, expSt, expFl, expBusy;
  int expV[8], expNv[8];
  logic [23:0] edges[9] = '{24'h000000, 24'h000fff, 24'h07ffff,
    24'h080000, 24'h0fffff, 24'h100000, 24'h1ff000, 24'h1fffff,
    24'h200000};
  sector_info_type smallMap[2];

  host_link_model host_link_model_i (.linkClk(linkClk),
    .chipSelect_n(chipSelect_n), .linkData(linkData));
  // short nonvolatile time: 10 clk of busy
  xspi_regwrite #(.NV_WRITE_TIME(1000)) xspi_regwrite_i (
    .clk(clk), .reset_n(reset_n), .linkClk(linkClk),
    .chipSelect_n(chipSelect_n), .linkData(linkData),
    .writeProtect_n(writeProtect_n), .dtrMode(dtrMode),
    .eraseAddr(eraseAddr), .statusReg(statusReg),
    .flagStatus(flagStatus), .nvConfig(nvConfig),
    .vConfig(vConfig), .sectorInfo(sectorInfo));
  // map-only copies at the two smaller densities; link held idle
  for (genvar g = 0; g < 2; g++) begin : density
    xspi_regwrite #(.DENSITY_MBIT(4 << g)) xspi_regwrite_i (
      .clk(clk), .reset_n(reset_n), .linkClk(1'b0), .chipSelect_n(1'b1),
      .linkData(8'h00), .writeProtect_n(1'b1), .dtrMode(1'b0),
      .eraseAddr(eraseAddr), .statusReg(), .flagStatus(), .nvConfig(),
      .vConfig(), .sectorInfo(smallMap[g]));
  end

  // ****************************************
  // checking and reference model
  // ****************************************
  task automatic check(input string what, input logic [63:0] seen,
      input logic [63:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic model(input logic [7:0] f[$]);
    int n, r;
    expBusy = 0;
    r = f[1];
    n = f.size() - 2;
    if (dtrMode) n = n & ~1;
    if (f[0] == OP_WRITE_ENABLE) expSt[1] = 1;
    else if (f[0] == OP_CLEAR_FLAGS) expFl &= ~{24'h0, FLAG_ERROR_MASK};
    else if (expSt[1] && f[0] == OP_WRITE_STATUS) begin
      expBusy = 1;
      if (expSt[7] && !writeProtect_n) expFl[1] = 1;
      else expSt = (expSt & 3) | (f[1] & STATUS_WRITABLE_MASK);
    end else if (expSt[1] && f[0] inside {OP_WRITE_VCFG, OP_WRITE_NVCFG}) begin
      if (r >= 8 || (dtrMode && r[0]) || n <= 0) expFl[4] = 1;
      else begin
        expBusy = (f[0] == OP_WRITE_NVCFG);
        for (int j = 0; j < n && r + j < 8; j++) begin
          if (f[0] == OP_WRITE_NVCFG) expNv[r+j] = f[j+2];
          else expV[r+j] = (expV[r+j] & 8'hc0) | (f[j+2] & 8'h3f);
        end
      end
    end
  endtask

  task automatic checkRegs;
    logic [63:0] v, nv;
    foreach (expV[i]) begin
      v[8*i+:8] = expV[i][7:0];
      nv[8*i+:8] = expNv[i][7:0];
    end
    check("status", statusReg, expSt);
    check("flags", flagStatus, expFl | 8'h80);
    check("vcfg", vConfig, v);
    check("nvcfg", nvConfig, nv);
  endtask

  task automatic frame(input logic [7:0] f[$]);
    int w;
    host_link_model_i.sendFrame(f);
    model(f);
    repeat (6) @(negedge clk);
    check("busy", statusReg[0], expBusy[0]);
    w = 0;
    while (statusReg[0] !== 1'b0 && w < 50) begin
      @(negedge clk);
      w++;
    end
    check("busy end", statusReg[0], 1'b0);
    repeat (2) @(negedge clk);
    checkRegs();
  endtask

  // ****************************************
  // clock, watchdog and sequence
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles >= 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    reset_n = 1'b0;
    writeProtect_n = 1'b1;
    dtrMode = 1'b0;
    eraseAddr = '0;
    void'($urandom(98));
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    @(negedge clk);
    checkRegs();
    frame('{OP_WRITE_STATUS, 8'hfc});
    frame('{OP_WRITE_ENABLE});
    for (int k = 0; k < 4; k++) frame('{OP_WRITE_STATUS, 8'($urandom)&8'h7f});
    frame('{OP_WRITE_STATUS, 8'h80});
    writeProtect_n = 1'b0;
    frame('{OP_WRITE_STATUS, 8'h0c});
    frame('{OP_CLEAR_FLAGS});
    writeProtect_n = 1'b1;
    for (int d = 0; d < 2; d++) begin
      dtrMode = d[0];
      frame('{OP_WRITE_VCFG, 8'h06, 8'($urandom), 8'($urandom), 8'h55});
      frame('{OP_WRITE_VCFG, 8'h03, 8'($urandom), 8'($urandom)});
      frame('{OP_WRITE_VCFG, 8'h04, 8'($urandom)});
      frame('{OP_WRITE_VCFG, 8'h08, 8'h11});
      // low byte first, reserved bits kept clear
      frame('{OP_WRITE_NVCFG, 8'h00, 8'($urandom)&8'h3f, 8'h2a, 8'h15});
      frame('{OP_CLEAR_FLAGS});
    end
    for (int k = 0; k < 24; k++) begin
      a = (k < 9) ? edges[k] : 24'($urandom) & 24'h3fffff;
      eraseAddr = a;
      repeat (2) @(negedge clk);
      check("sub4", sectorInfo.sub4, a[20:12]);
      check("sector", {sectorInfo.sector, sectorInfo.sub32},
        {a[20:16], a[20:15]});
      check("start", sectorInfo.sub4Start, {a[23:12], 12'h000});
      check("range", sectorInfo.inRange, a <= TOP_ADDR_16M);
      check("range4", smallMap[0].inRange, a <= TOP_ADDR_4M);
      check("range8", smallMap[1].inRange, a <= TOP_ADDR_8M);
    end
    print_verdict();
  end
endmodule
